// [inc/udetc_consts.svh]
`ifndef UDETC_CONSTS_SVH
`define UDETC_CONSTS_SVH
// Receive control/status bit positions.
`define UDETC_RX_PKT_READY_BIT    0
`define UDETC_RX_STALL_REQ_BIT    5
`define UDETC_RX_STALL_FLAG_BIT   6
`define UDETC_RX_TOGGLE_RST_BIT   7
`define UDETC_RX_NYET_SUPP_BIT    12
// Transmit control/status, FIFO and power bit positions.
`define UDETC_TX_PKT_READY_BIT    0
`define UDETC_TX_UNDERRUN_BIT     2
`define UDETC_TX_DMA_MODE_BIT     10
`define UDETC_TX_FORCE_TOG_BIT    11
`define UDETC_TX_DMA_EN_BIT       12
`define UDETC_TX_ISO_BIT          14
`define UDETC_FIFO_DPB_BIT        4
`define UDETC_POWER_ISO_HOLD_BIT  7
// Frame timing: 125 us microframe at 100 MHz.
`define UDETC_FRAME_NS            125000
`define UDETC_CLK_NS              10
`define UDETC_FRAME_CYCLES        (`UDETC_FRAME_NS / `UDETC_CLK_NS)
`define UDETC_SOF_MARGIN_CYCLES   16
`endif

// [inc/udetc_pkg.sv]
package udetc_pkg;
   // Handshake codes returned to the bus engine.
   typedef enum logic [1:0] {
      UDETC_HS_ACK,
      UDETC_HS_NAK,
      UDETC_HS_STALL,
      UDETC_HS_NYET
   } udetc_hs_t;
   // Transmit endpoint sequencing.
   typedef enum logic [1:0] {
      UDETC_TX_IDLE,
      UDETC_TX_SEND,
      UDETC_TX_WAIT_ACK
   } udetc_tx_state_t;
endpackage

// [rtl/udetc_ctrl.sv]
`include "udetc_consts.svh"
`default_nettype none
module udetc_ctrl #(
   parameter int CNT_W = 11,
   parameter int FRAME_CYCLES = `UDETC_FRAME_CYCLES
) (
   input  wire logic                core_clk_in,
   input  wire logic                rst_in,
   // Bus engine side: received OUT packet, link speed and SOF.
   input  wire logic                rx_pkt_in,
   input  wire logic [CNT_W-1:0]    rx_len_in,
   input  wire logic                high_speed_in,
   input  wire logic                sof_pkt_in,
   // Bus engine side: IN token and its handshake.
   input  wire logic                in_token_in,
   input  wire logic                in_ack_in,
   input  wire logic                in_timeout_in,
   // Software side controls.
   input  wire logic                rx_ready_clear_in,
   input  wire logic                stall_request_in,
   input  wire logic                stall_flag_clear_in,
   input  wire logic                toggle_restart_in,
   input  wire logic                nyet_suppress_in,
   input  wire logic                tx_load_in,
   input  wire logic                tx_zero_len_in,
   input  wire logic                forced_toggle_in,
   input  wire logic                iso_mode_in,
   input  wire logic                dma_request_enable_in,
   input  wire logic                dma_completion_irq_suppress_in,
   input  wire logic                double_buffer_enable_in,
   input  wire logic                hold_until_next_frame_in,
   input  wire logic                tx_endpoint_irq_enable_in,
   input  wire logic                underrun_clear_in,
   // Outputs.
   output udetc_pkg::udetc_hs_t     rx_handshake_out,
   output logic                     rx_handshake_valid_out,
   output logic                     rx_packet_ready_out,
   output logic [CNT_W-1:0]         rx_byte_count_out,
   output logic                     stall_issued_flag_out,
   output logic                     rx_toggle_out,
   output logic                     rx_irq_out,
   output logic                     tx_send_out,
   output logic                     tx_send_zero_len_out,
   output logic                     tx_toggle_out,
   output logic                     tx_packet_ready_out,
   output logic                     tx_underrun_out,
   output logic                     tx_irq_out,
   output logic                     dma_req_out,
   output logic                     sof_pulse_out
);
   import udetc_pkg::*;

   if (CNT_W < 4 || CNT_W > 16 || FRAME_CYCLES < 2 * `UDETC_SOF_MARGIN_CYCLES) begin : g_bad_param
      $error("udetc_ctrl parameters out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers for the rx_ready_clear_in and tx_load_in strobes that arrive from outside.
   logic [1:0] s1_q, s2_q;
   logic       rxclr_prev_q, load_prev_q;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_q         <= 2'h0;
         s2_q         <= 2'h0;
         rxclr_prev_q <= 1'b0;
         load_prev_q  <= 1'b0;
      end else begin
         s1_q         <= {tx_load_in, rx_ready_clear_in};
         s2_q         <= s1_q;
         rxclr_prev_q <= s2_q[0];
         load_prev_q  <= s2_q[1];
      end
   end
   wire rx_clr_ev = s2_q[0] & ~rxclr_prev_q;
   wire tx_ld_ev  = s2_q[1] & ~load_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Two-entry receive buffer of byte counts; head is presented to software.
   logic [CNT_W-1:0] rx_cnt_q [2];
   logic [CNT_W-1:0] rx_cnt_d [2];
   logic [1:0]       rx_fill_q, rx_fill_d;
   logic             rx_tog_q, rx_tog_d;
   logic             stall_flag_q, stall_flag_d;
   udetc_hs_t        hs_q, hs_d;
   logic             hs_v_q, hs_v_d;
   logic             rx_irq_q, rx_irq_d;
   logic             rx_rdy_q, rx_rdy_d;

   // Receive path next state: stall, accept, NAK when full, release slot.
   always_comb begin
      logic [1:0] cap;
      cap          = double_buffer_enable_in ? 2'h2 : 2'h1;
      rx_cnt_d     = rx_cnt_q;
      rx_fill_d    = rx_fill_q;
      rx_tog_d     = rx_tog_q;
      stall_flag_d = stall_flag_q;
      hs_d         = hs_q;
      hs_v_d       = 1'b0;
      rx_irq_d     = 1'b0;
      if (stall_flag_clear_in) begin
         stall_flag_d = 1'b0;
      end
      if (rx_clr_ev && rx_fill_q != 2'h0) begin
         rx_cnt_d[0] = rx_cnt_q[1];
         rx_fill_d   = rx_fill_q - 2'h1;
      end
      if (toggle_restart_in) begin
         rx_tog_d = 1'b0;
      end
      if (rx_pkt_in) begin
         hs_v_d = 1'b1;
         if (stall_request_in) begin
            hs_d         = UDETC_HS_STALL;
            stall_flag_d = 1'b1;
            rx_irq_d     = 1'b1;
         end else if (rx_fill_d >= cap) begin
            hs_d = UDETC_HS_NAK;
         end else begin
            // Bulk and interrupt OUT share this path.
            rx_cnt_d[rx_fill_d[0]] = rx_len_in;
            rx_fill_d = rx_fill_d + 2'h1;
            rx_tog_d  = ~rx_tog_d;
            rx_irq_d  = 1'b1;
            if (high_speed_in && !nyet_suppress_in && rx_fill_d >= cap) begin
               hs_d = UDETC_HS_NYET;
            end else begin
               hs_d = UDETC_HS_ACK;
            end
         end
      end
      rx_rdy_d = (rx_fill_d != 2'h0);
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_rdy_q     <= 1'b0;
         rx_cnt_q[0]  <= '0;
         rx_cnt_q[1]  <= '0;
         rx_fill_q    <= 2'h0;
         rx_tog_q     <= 1'b0;
         stall_flag_q <= 1'b0;
         hs_q         <= UDETC_HS_ACK;
         hs_v_q       <= 1'b0;
         rx_irq_q     <= 1'b0;
      end else begin
         rx_rdy_q     <= rx_rdy_d;
         rx_cnt_q     <= rx_cnt_d;
         rx_fill_q    <= rx_fill_d;
         rx_tog_q     <= rx_tog_d;
         stall_flag_q <= stall_flag_d;
         hs_q         <= hs_d;
         hs_v_q       <= hs_v_d;
         rx_irq_q     <= rx_irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame counter: realigned by SOF packets, free-runs when one is lost.
   logic [31:0] fcnt_q, fcnt_d;
   logic        sof_q, sof_d;
   always_comb begin
      fcnt_d = fcnt_q + 32'h1;
      sof_d  = 1'b0;
      if (sof_pkt_in) begin
         fcnt_d = 32'h0;
         sof_d  = 1'b1;
      end else if (fcnt_q >= 32'(FRAME_CYCLES + `UDETC_SOF_MARGIN_CYCLES - 1)) begin
         fcnt_d = 32'(`UDETC_SOF_MARGIN_CYCLES);
         sof_d  = 1'b1;
      end
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         fcnt_q <= 32'h0;
         sof_q  <= 1'b0;
      end else begin
         fcnt_q <= fcnt_d;
         sof_q  <= sof_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit buffer: packet count, armed count, zero-length marks, toggle.
   logic [1:0]      tx_fill_q, tx_fill_d;
   logic [1:0]      tx_arm_q, tx_arm_d;
   logic [1:0]      tx_zl_q, tx_zl_d;
   logic            tx_tog_q, tx_tog_d;
   logic            tx_rdy_q, tx_rdy_d;
   logic            undr_q, undr_d;
   logic            send_q, send_d;
   logic            szl_q, szl_d;
   logic            tx_irq_q, tx_irq_d;
   logic            dma_q, dma_d;
   udetc_tx_state_t tst_q, tst_d;

   always_comb begin
      logic [1:0] cap;
      logic       done;
      logic       irq_ok;
      cap       = double_buffer_enable_in ? 2'h2 : 2'h1;
      done      = 1'b0;
      irq_ok    = !(dma_request_enable_in && dma_completion_irq_suppress_in);
      tx_fill_d = tx_fill_q;
      tx_arm_d  = tx_arm_q;
      tx_zl_d   = tx_zl_q;
      tx_tog_d  = tx_tog_q;
      tx_rdy_d  = tx_rdy_q;
      undr_d    = undr_q;
      send_d    = 1'b0;
      szl_d     = 1'b0;
      tst_d     = tst_q;
      if (underrun_clear_in) begin
         undr_d = 1'b0;
      end
      // A SOF releases every held packet.
      if (sof_q) begin
         tx_arm_d = tx_fill_q;
      end
      case (tst_q)
         UDETC_TX_IDLE: begin
            if (in_token_in) begin
               if (tx_arm_d != 2'h0) begin
                  send_d = 1'b1;
                  szl_d  = tx_zl_q[0];
                  tst_d  = iso_mode_in ? UDETC_TX_IDLE : UDETC_TX_WAIT_ACK;
                  if (iso_mode_in) begin
                     done = 1'b1;
                  end
               end else if (iso_mode_in) begin
                  send_d = 1'b1;
                  szl_d  = 1'b1;
                  undr_d = 1'b1;
               end
            end
         end
         UDETC_TX_WAIT_ACK: begin
            if (in_ack_in || (in_timeout_in && forced_toggle_in)) begin
               done  = 1'b1;
               tst_d = UDETC_TX_IDLE;
            end else if (in_timeout_in) begin
               tst_d = UDETC_TX_IDLE;
            end
         end
         default: tst_d = UDETC_TX_IDLE;
      endcase
      if (done) begin
         tx_fill_d = tx_fill_d - 2'h1;
         tx_arm_d  = tx_arm_d - 2'h1;
         tx_zl_d   = {1'b0, tx_zl_q[1]};
         if (!iso_mode_in) begin
            tx_tog_d = ~tx_tog_q;
         end
      end
      if (tx_ld_ev && tx_fill_d < cap) begin
         tx_zl_d[tx_fill_d[0]] = tx_zero_len_in;
         tx_fill_d = tx_fill_d + 2'h1;
         if (!(iso_mode_in && hold_until_next_frame_in)) begin
            tx_arm_d = tx_arm_d + 2'h1;
         end
      end
      tx_rdy_d = (tx_fill_d >= cap);
      tx_irq_d = tx_endpoint_irq_enable_in &&
                 ((done && irq_ok) || (send_d && szl_d && undr_d && !undr_q));
      dma_d    = dma_request_enable_in && (tx_fill_d < cap);
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_fill_q <= 2'h0;
         tx_arm_q  <= 2'h0;
         tx_zl_q   <= 2'h0;
         tx_tog_q  <= 1'b0;
         tx_rdy_q  <= 1'b0;
         undr_q    <= 1'b0;
         send_q    <= 1'b0;
         szl_q     <= 1'b0;
         tx_irq_q  <= 1'b0;
         dma_q     <= 1'b0;
         tst_q     <= UDETC_TX_IDLE;
      end else begin
         tx_fill_q <= tx_fill_d;
         tx_arm_q  <= tx_arm_d;
         tx_zl_q   <= tx_zl_d;
         tx_tog_q  <= tx_tog_d;
         tx_rdy_q  <= tx_rdy_d;
         undr_q    <= undr_d;
         send_q    <= send_d;
         szl_q     <= szl_d;
         tx_irq_q  <= tx_irq_d;
         dma_q     <= dma_d;
         tst_q     <= tst_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all taken from flip-flops.
   assign rx_handshake_out       = hs_q;
   assign rx_handshake_valid_out = hs_v_q;
   assign rx_packet_ready_out    = rx_rdy_q;
   assign rx_byte_count_out      = rx_cnt_q[0];
   assign stall_issued_flag_out  = stall_flag_q;
   assign rx_toggle_out          = rx_tog_q;
   assign rx_irq_out             = rx_irq_q;
   assign tx_send_out            = send_q;
   assign tx_send_zero_len_out   = szl_q;
   assign tx_toggle_out          = tx_tog_q;
   assign tx_packet_ready_out    = tx_rdy_q;
   assign tx_underrun_out        = undr_q;
   assign tx_irq_out             = tx_irq_q;
   assign dma_req_out            = dma_q;
   assign sof_pulse_out          = sof_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   stall_answer_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      rx_pkt_in && stall_request_in |=> hs_v_q && hs_q == UDETC_HS_STALL && stall_flag_q)
      else $error("stall not answered");
   rx_accept_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      rx_pkt_in && !stall_request_in && rx_fill_q == 2'h0 |=> rx_packet_ready_out && rx_irq_q)
      else $error("accepted packet not flagged");
   nyet_block_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      $past(nyet_suppress_in) && hs_v_q |-> hs_q != UDETC_HS_NYET)
      else $error("nyet sent while suppressed");
   toggle_clear_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      toggle_restart_in && !rx_pkt_in |=> !rx_tog_q)
      else $error("toggle not restarted");
   sof_follow_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      sof_pkt_in |=> sof_pulse_out)
      else $error("sof pulse missing");
   dma_room_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      dma_q |-> !tx_rdy_q)
      else $error("dma request while full");
   underrun_zlp_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      tst_q == UDETC_TX_IDLE && in_token_in && iso_mode_in && tx_fill_q == 2'h0 && !sof_q
      |=> tx_send_out && tx_send_zero_len_out && tx_underrun_out)
      else $error("underrun not reported");
   irq_gate_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !$past(tx_endpoint_irq_enable_in) |-> !tx_irq_q)
      else $error("tx interrupt while disabled");
   hold_frame_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      tx_arm_q == 2'h0 && !sof_q && iso_mode_in && hold_until_next_frame_in && in_token_in
      |=> tx_send_zero_len_out || !tx_send_out)
      else $error("held packet sent early");
endmodule // udetc_ctrl
`default_nettype wire

// [bench/udetc_host_model.sv]
`default_nettype none
module udetc_host_model #(
   parameter int CNT_W   = 11,
   parameter int MAX_PKT = 64
) (
   input  wire logic             core_clk_in,
   output logic                  rx_pkt_out,
   output logic [CNT_W-1:0]      rx_len_out,
   output logic                  sof_pkt_out,
   output logic                  in_token_out,
   output logic                  in_ack_out,
   output logic                  in_timeout_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] strb_q;
   logic       tok_seen;
   // Strobe bits are SOF, IN token, ACK and no-ACK, in that order.
   assign sof_pkt_out    = strb_q[0];
   assign in_token_out   = strb_q[1];
   assign in_ack_out     = strb_q[2];
   assign in_timeout_out = strb_q[3];
   // Everything starts idle.
   initial begin
      rx_pkt_out = 1'b0;
      rx_len_out = '0;
      strb_q     = '0;
      tok_seen   = 1'b0;
   end
   // Sends one OUT data packet; the length lines show junk once it is gone.
   task automatic out_pkt(input logic [CNT_W-1:0] len);
      @(posedge core_clk_in);
      rx_pkt_out <= 1'b1;
      rx_len_out <= (len > MAX_PKT) ? MAX_PKT[CNT_W-1:0] : len;
      @(posedge core_clk_in);
      rx_pkt_out <= 1'b0;
      rx_len_out <= ~rx_len_out;
   endtask
   // Splits a block into full packets and ends it with a short or empty one.
   task automatic out_block(input int total);
      int left;
      left = total;
      while (left >= MAX_PKT) begin
         out_pkt(MAX_PKT[CNT_W-1:0]);
         left = left - MAX_PKT;
      end
      out_pkt(left[CNT_W-1:0]);
   endtask
   // Raises one strobe for a single cycle; an SOF opens a new frame.
   task automatic strobe(input int sel);
      @(posedge core_clk_in);
      strb_q[sel] <= 1'b1;
      if (sel == 0) tok_seen = 1'b0;
      @(posedge core_clk_in);
      strb_q[sel] <= 1'b0;
   endtask
   // Only one isochronous token per frame, so a second one is sent after an SOF of its own.
   task automatic iso_token();
      if (tok_seen) strobe(0);
      tok_seen = 1'b1;
      strobe(1);
   endtask
endmodule // udetc_host_model
`default_nettype wire

// [bench/testbench.sv]
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import udetc_pkg::*;
   localparam int CNT_W = 11;
   logic clk, rst, hs_link, rx_clr, stall_req, nyet_sup, tx_load, tx_zl, frc_tog;
   logic iso, dma_en, dma_sup, dbl, hold, irq_en;
   logic [2:0] lvl;
   wire logic rx_pkt, sof_pkt, in_tok, in_ack, in_to;
   wire logic [CNT_W-1:0] rx_len;
   udetc_hs_t rx_hs;
   logic rx_hs_v, rx_rdy, st_flag, rx_tog, rx_irq, tx_send, tx_zlo, tx_tog, tx_rdy, tx_und;
   logic tx_irq, dma_req, sof_pulse;
   logic [CNT_W-1:0] rx_cnt, len_a, len_b;
   udetc_hs_t rx_q[$];
   logic tx_q[$];
   int miscompares, cmp_count, cyc_cnt, rx_irq_n, tx_irq_n, sof_n, data_n, n, d;
   logic t;
   logic [1:0] zl;
   udetc_host_model #(.CNT_W(CNT_W)) udetc_host_model_inst (.core_clk_in(clk),
      .rx_pkt_out(rx_pkt), .rx_len_out(rx_len), .sof_pkt_out(sof_pkt),
      .in_token_out(in_tok), .in_ack_out(in_ack), .in_timeout_out(in_to));
   udetc_ctrl #(.CNT_W(CNT_W), .FRAME_CYCLES(64)) udetc_ctrl_inst (.core_clk_in(clk),
      .rst_in(rst), .rx_pkt_in(rx_pkt), .rx_len_in(rx_len), .high_speed_in(hs_link),
      .sof_pkt_in(sof_pkt), .in_token_in(in_tok), .in_ack_in(in_ack), .in_timeout_in(in_to),
      .rx_ready_clear_in(rx_clr), .stall_request_in(stall_req), .stall_flag_clear_in(lvl[0]),
      .toggle_restart_in(lvl[1]), .nyet_suppress_in(nyet_sup), .tx_load_in(tx_load),
      .tx_zero_len_in(tx_zl), .forced_toggle_in(frc_tog), .iso_mode_in(iso),
      .dma_request_enable_in(dma_en), .dma_completion_irq_suppress_in(dma_sup),
      .double_buffer_enable_in(dbl), .hold_until_next_frame_in(hold),
      .tx_endpoint_irq_enable_in(irq_en), .underrun_clear_in(lvl[2]),
      .rx_handshake_out(rx_hs), .rx_handshake_valid_out(rx_hs_v), .rx_packet_ready_out(rx_rdy),
      .rx_byte_count_out(rx_cnt), .stall_issued_flag_out(st_flag), .rx_toggle_out(rx_tog),
      .rx_irq_out(rx_irq), .tx_send_out(tx_send), .tx_send_zero_len_out(tx_zlo),
      .tx_toggle_out(tx_tog), .tx_packet_ready_out(tx_rdy), .tx_underrun_out(tx_und),
      .tx_irq_out(tx_irq), .dma_req_out(dma_req), .sof_pulse_out(sof_pulse));
   ////////////////////////////////////////////////////////////////////////
   // Free-running 100 MHz clock.
   always #5 clk = ~clk;
   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic test_done();
      $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Waits whole cycles and lets the edge updates settle.
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // Pulses one same-clock clear input for a cycle.
   task automatic clr_pulse(input int i);
      @(posedge clk);
      lvl[i] <= 1'b1;
      @(posedge clk);
      lvl[i] <= 1'b0;
      cyc(2);
   endtask
   // The release and load strobes are synchronised, so they are held long enough.
   task automatic rx_release();
      @(posedge clk);
      rx_clr <= 1'b1;
      cyc(2);
      @(posedge clk);
      rx_clr <= 1'b0;
      cyc(5);
   endtask
   task automatic load(input logic zl);
      @(posedge clk);
      tx_zl   <= zl;
      tx_load <= 1'b1;
      cyc(2);
      @(posedge clk);
      tx_load <= 1'b0;
      cyc(5);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Watches the outputs, matches results to the oldest note and counts pulses.
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         miscompares++;
         test_done();
      end
      if (rx_hs_v === 1'b1) begin
         if (rx_q.size() > 0) chk(rx_hs, rx_q.pop_front());
         else chk(32'hFFFF, rx_hs);
      end
      if (tx_send === 1'b1) begin
         if (tx_q.size() > 0) chk(tx_zlo, tx_q.pop_front());
         else chk(32'hFFFF, tx_zlo);
         if (tx_zlo === 1'b0) data_n++;
      end
      if (rx_irq === 1'b1) rx_irq_n++;
      if (tx_irq === 1'b1) tx_irq_n++;
      if (sof_pulse === 1'b1) sof_n++;
   end
   // Main sequence.
   initial begin
      void'($urandom(18));
      {clk, hs_link, rx_clr, stall_req, nyet_sup, tx_load, tx_zl, frc_tog} = '0;
      {iso, dma_en, dma_sup, dbl, hold, irq_en, lvl} = '0;
      {miscompares, cmp_count, cyc_cnt, rx_irq_n, tx_irq_n, sof_n, data_n} = '0;
      rst = 1'b1;
      hs_link = 1'b1;
      irq_en = 1'b1;
      // The receive side runs with its two-entry buffer first.
      dbl = 1'b1;
      len_a = CNT_W'($urandom_range(1, 64));
      len_b = CNT_W'($urandom_range(1, 64));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
      chk({rx_rdy, tx_rdy, st_flag, tx_und, rx_tog, tx_tog}, 0);
      rx_q.push_back(UDETC_HS_ACK);
      udetc_host_model_inst.out_pkt(len_a);
      cyc(2);
      chk(rx_rdy, 1);
      chk(rx_irq_n, 1);
      chk(rx_cnt, len_a);
      chk(rx_tog, 1);
      clr_pulse(1);
      chk(rx_tog, 0);
      rx_q.push_back(UDETC_HS_NYET);
      udetc_host_model_inst.out_pkt(len_b);
      rx_q.push_back(UDETC_HS_NAK);
      udetc_host_model_inst.out_pkt(len_a);
      cyc(2);
      rx_release();
      chk(rx_rdy, 1);
      chk(rx_cnt, len_b);
      rx_release();
      chk(rx_rdy, 0);
      // With NYET suppressed the full buffer takes a plain ACK at either speed.
      nyet_sup <= 1'b1;
      hs_link <= 1'($urandom_range(0, 1));
      rx_q.push_back(UDETC_HS_ACK);
      rx_q.push_back(UDETC_HS_ACK);
      rx_q.push_back(UDETC_HS_NAK);
      udetc_host_model_inst.out_block(128);
      cyc(2);
      rx_release();
      rx_release();
      n = rx_irq_n;
      stall_req <= 1'b1;
      rx_q.push_back(UDETC_HS_STALL);
      udetc_host_model_inst.out_pkt(len_a);
      cyc(2);
      chk(st_flag, 1);
      clr_pulse(0);
      chk(st_flag, 0);
      rx_q.push_back(UDETC_HS_STALL);
      udetc_host_model_inst.out_pkt(len_b);
      cyc(2);
      chk(st_flag, 1);
      chk(rx_irq_n, n + 2);
      chk(rx_rdy, 0);
      stall_req <= 1'b0;
      dbl <= 1'b0;
      nyet_sup <= 1'($urandom_range(0, 1));
      clr_pulse(0);
      // Bulk IN, then forced toggle with the interrupt masked.
      for (int k = 0; k < 2; k++) begin
         load(1'b0);
         chk(tx_rdy, 1);
         n = tx_irq_n;
         t = tx_tog;
         tx_q.push_back(1'b0);
         udetc_host_model_inst.strobe(1);
         cyc(3);
         udetc_host_model_inst.strobe(k + 2);
         cyc(2);
         chk(tx_tog, !t);
         chk(tx_irq_n, n + 1 - k);
         chk(tx_rdy, 0);
         irq_en <= 1'b0;
         frc_tog <= 1'b1;
      end
      frc_tog <= 1'b0;
      irq_en <= 1'b1;
      dbl <= 1'b1;
      dma_en <= 1'b1;
      dma_sup <= 1'b1;
      cyc(2);
      chk(dma_req, 1);
      zl = 2'($urandom_range(0, 3));
      load(zl[0]);
      chk(tx_rdy, 0);
      load(zl[1]);
      chk(tx_rdy, 1);
      chk(dma_req, 0);
      n = tx_irq_n;
      for (int k = 0; k < 2; k++) begin
         tx_q.push_back(zl[k]);
         udetc_host_model_inst.strobe(1);
         cyc(2);
         udetc_host_model_inst.strobe(2);
         cyc(2);
      end
      chk(tx_irq_n, n);
      chk(dma_req, 1);
      {dbl, dma_en} <= '0;
      // Completion suppress and forced toggle mean nothing here, so they are random.
      dma_sup <= 1'($urandom_range(0, 1));
      frc_tog <= 1'($urandom_range(0, 1));
      t = tx_tog;
      iso <= 1'b1;
      tx_q.push_back(1'b1);
      udetc_host_model_inst.iso_token();
      cyc(2);
      chk(tx_und, 1);
      clr_pulse(2);
      hold <= 1'b1;
      udetc_host_model_inst.strobe(0);
      load(1'b0);
      d = data_n;
      tx_q.push_back(1'b1);
      udetc_host_model_inst.iso_token();
      cyc(3);
      chk(data_n, d);
      clr_pulse(2);
      n = tx_irq_n;
      tx_q.push_back(1'b0);
      udetc_host_model_inst.iso_token();
      cyc(3);
      chk(data_n, d + 1);
      chk(tx_irq_n, n + 1);
      chk(tx_tog, t);
      tx_q.push_back(1'b1);
      udetc_host_model_inst.iso_token();
      cyc(3);
      chk(data_n, d + 1);
      n = sof_n;
      udetc_host_model_inst.strobe(0);
      cyc(2);
      chk(sof_n, n + 1);
      cyc(84);
      chk(sof_n, n + 2);
      chk(rx_q.size() + tx_q.size(), 0);
      test_done();
   end
endmodule // testbench
`default_nettype wire
